// >>> rtl/pdic_regs.svh
// Register offsets, field positions, reset values and timing counts of the power controller.
// Assumes it is included by bare name after the package is compiled.
`ifndef PDIC_REGS_SVH
`define PDIC_REGS_SVH

// =============================================================
// Register map
`define PDIC_POWER_CONTROL_ADDR 8'h87
`define PDIC_POWER_CONTROL_RST  8'h10
`define PDIC_POWER_CONTROL_WMSK 8'hDF

// =============================================================
// Field positions
`define PDIC_BIT_CPU_HALT     0
`define PDIC_BIT_POWER_DOWN   1
`define PDIC_BIT_USER_FLAG0   2
`define PDIC_BIT_USER_FLAG1   3
`define PDIC_BIT_COLD_START   4
`define PDIC_BIT_RESERVED     5
`define PDIC_BIT_VIEW_SELECT  6
`define PDIC_BIT_BAUD_DOUBLER 7

// =============================================================
// Timing counts in oscillator clocks
`define PDIC_KBD_WAKE_CLKS 1024
`define PDIC_RST_HOLD_CLKS 24

`endif

// >>> rtl/pdic_pkg.sv
// Types shared by the power controller files.
// Assumes it is compiled before every other file of the block.
`default_nettype none

package pdic_pkg;

	// =============================================================
	// Mode states
	typedef enum logic [2:0] {
		PDIC_RUN,
		PDIC_IDLE,
		PDIC_PDOWN,
		PDIC_OSC_ON,
		PDIC_KBD_WAIT,
		PDIC_WAKE
	} pdic_state_t;

	// =============================================================
	// Wake sources, also the index into the source masks
	typedef enum logic [1:0] {
		PDIC_SRC_EXT0,
		PDIC_SRC_EXT1,
		PDIC_SRC_KBD,
		PDIC_SRC_USB
	} pdic_src_t;

	// =============================================================
	// Special function register access from the core
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} pdic_sfr_req_t;

	// =============================================================
	// Port pin drive of ports 0 and 2
	typedef struct packed {
		logic [7:0] p0_do;
		logic [7:0] p0_oe;
		logic [7:0] p2_do;
		logic [7:0] p2_oe;
	} pdic_pins_t;

endpackage

`default_nettype wire

// >>> rtl/pdic_sync.sv
// Two-stage synchroniser for pins that arrive from outside the clock domain.
// Assumes one clock, an active-low asynchronous reset and a clock enable.
`default_nettype none

module pdic_sync #(
	parameter int         WIDTH    = 2,
	parameter logic [7:0] RST_VAL  = 8'hFF
) (
	input  wire logic             clk_in,
	input  wire logic             rst_b_in,
	input  wire logic             clk_en_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;

	if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
		$error("pdic_sync: WIDTH must lie between 1 and 8.");
	end

	// =============================================================
	// Synchroniser stages
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			meta_r   <= RST_VAL[WIDTH-1:0];
			sync_out <= RST_VAL[WIDTH-1:0];
		end else if (clk_en_in) begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule

`default_nettype wire

// >>> rtl/pdic_top.sv
// Idle and power-down controller: power control register, mode sequencing and wake-up.
// Assumes the core, the interrupt controller and the port latches sit on the inner side.
//
// Operation
// - Power-down bit stops oscillator after setting instruction.
// - Power-down keeps RAM and registers unchanged.
// - Only two pins, keyboard, USB wake power-down.
// - Wake source must be enabled and configured.
// - Keyboard wake waits 1024 clocks before resuming.
// - Pin low restarts oscillator, release completes exit.
// - Either pin low restarts; first release exits.
// - Higher priority source is serviced first.
// - Execution resumes after the power-down instruction.
// - Reset exit reinitialises registers; interrupt exit keeps.
// - No exit alters internal RAM.
// - Both bits set: power-down exit, both cleared.
// - Fetch strobes high in idle, low in power-down.
// - Ports hold data; with external program memory port 0 floats, port 2 addresses in idle only.
// - Bit 7 doubles baud; bit 6 picks view.
// - Cold start flag set on power-up, software clears.
// - Bits 3 and 2 are software flags.
// - Power-down bit cleared by any reset.
// - Halt bit cleared by interrupt or reset.
// - Reserved bit 5 always reads zero.
// - Idle stops only the CPU clock.
// - Idle reset pin held 24 clocks takes effect.
`include "pdic_regs.svh"
`default_nettype none

module pdic_top #(
	parameter int KBD_WAKE_CLKS = `PDIC_KBD_WAKE_CLKS,
	parameter int RST_HOLD_CLKS = `PDIC_RST_HOLD_CLKS
) (
	input  wire logic                   clk_in,
	input  wire logic                   rst_b_in,
	input  wire logic                   clk_en_in,
	input  wire pdic_pkg::pdic_sfr_req_t sfr_req_in,
	output logic [7:0]                  sfr_rdata_out,
	input  wire logic                   cold_power_up_in,
	input  wire logic                   reset_pin_in,
	input  wire logic [1:0]             ext_int_b_in,
	input  wire logic [1:0]             ext_int_edge_in,
	input  wire logic                   kbd_int_in,
	input  wire logic                   usb_int_in,
	input  wire logic [3:0]             wake_enable_in,
	input  wire logic [3:0]             wake_high_prio_in,
	input  wire logic                   idle_irq_in,
	input  wire logic                   ext_prog_mem_in,
	input  wire logic                   core_ale_in,
	input  wire logic                   core_prog_fetch_strobe_in,
	input  wire pdic_pkg::pdic_pins_t   core_pins_in,
	input  wire logic [7:0]             core_addr_hi_in,
	output pdic_pkg::pdic_pins_t        pins_out,
	output logic                        ale_out,
	output logic                        program_fetch_strobe_out,
	output logic                        osc_run_out,
	output logic                        cpu_clk_en_out,
	output logic                        periph_clk_en_out,
	output logic                        sfr_hold_out,
	output logic                        ram_hold_out,
	output logic                        core_reset_out,
	output logic                        wake_valid_out,
	output pdic_pkg::pdic_src_t         wake_src_out,
	output logic                        baud_doubler_out,
	output logic                        serial_bit_view_select_out
);

	// =============================================================
	// Elaboration checks
	if (KBD_WAKE_CLKS < 2 || KBD_WAKE_CLKS > 65535) begin : g_bad_kbd_clks
		$error("pdic_top: KBD_WAKE_CLKS must lie between 2 and 65535.");
	end
	if (RST_HOLD_CLKS < 2 || RST_HOLD_CLKS > 255) begin : g_bad_rst_clks
		$error("pdic_top: RST_HOLD_CLKS must lie between 2 and 255.");
	end

	// =============================================================
	// Priority selection among pending wake sources
	function automatic pdic_pkg::pdic_src_t pick_src(input logic [3:0] pend,
		input logic [3:0] hi);
		logic [3:0] hot;
		pdic_pkg::pdic_src_t sel;
		hot = pend & hi;
		if (hot == 4'h0) begin
			hot = pend;
		end
		if (hot[0]) begin
			sel = pdic_pkg::PDIC_SRC_EXT0;
		end else if (hot[1]) begin
			sel = pdic_pkg::PDIC_SRC_EXT1;
		end else if (hot[2]) begin
			sel = pdic_pkg::PDIC_SRC_KBD;
		end else begin
			sel = pdic_pkg::PDIC_SRC_USB;
		end
		return sel;
	endfunction

	// =============================================================
	// Declarations
	pdic_pkg::pdic_state_t state_r;
	pdic_pkg::pdic_state_t state_nxt;
	logic [7:0]            power_control_r;
	logic [7:0]            power_control_nxt;
	logic [3:0]            pend_r;
	logic [3:0]            pend_nxt;
	logic [15:0]           kbd_cnt_r;
	logic [15:0]           kbd_cnt_nxt;
	logic [7:0]            rst_cnt_r;
	logic [1:0]            ext_s;
	logic [1:0]            ext_prev_r;
	logic                  rst_pin_s;
	logic [7:0]            addr_hold_r;

	// =============================================================
	// Pin synchronisers
	pdic_sync #(
		.WIDTH   (2),
		.RST_VAL (8'hFF)
	) u_ext_sync (
		.clk_in    (clk_in),
		.rst_b_in  (rst_b_in),
		.clk_en_in (clk_en_in),
		.async_in  (ext_int_b_in),
		.sync_out  (ext_s)
	);

	pdic_sync #(
		.WIDTH   (1),
		.RST_VAL (8'h00)
	) u_rst_sync (
		.clk_in    (clk_in),
		.rst_b_in  (rst_b_in),
		.clk_en_in (clk_en_in),
		.async_in  (reset_pin_in),
		.sync_out  (rst_pin_s)
	);

	// =============================================================
	// Decode
	wire       sfr_hit   = sfr_req_in.addr == `PDIC_POWER_CONTROL_ADDR;
	wire       sfr_wr    = sfr_hit && sfr_req_in.wr;
	wire       sfr_rd    = sfr_hit && sfr_req_in.rd;
	wire       power_down_request_bit = power_control_r[`PDIC_BIT_POWER_DOWN];
	wire       cpu_halt_bit           = power_control_r[`PDIC_BIT_CPU_HALT];
	wire       in_pdown  = state_r == pdic_pkg::PDIC_PDOWN
	                    || state_r == pdic_pkg::PDIC_OSC_ON
	                    || state_r == pdic_pkg::PDIC_KBD_WAIT;
	wire       in_idle   = state_r == pdic_pkg::PDIC_IDLE;
	wire [1:0] ext_low   = wake_enable_in[1:0] & ~ext_s
	                    & (~ext_int_edge_in | ext_prev_r);
	wire [1:0] ext_rise  = pend_r[1:0] & ext_s & ~ext_prev_r;
	wire       kbd_wake  = wake_enable_in[2] && kbd_int_in;
	wire       usb_wake  = wake_enable_in[3] && usb_int_in;
	wire       kbd_done  = kbd_cnt_r == 16'(KBD_WAKE_CLKS - 1);
	wire       rst_hit   = rst_pin_s && rst_cnt_r == 8'(RST_HOLD_CLKS - 1);
	wire       rst_held  = rst_pin_s && rst_cnt_r == 8'(RST_HOLD_CLKS);
	wire       sw_write  = sfr_wr && state_r == pdic_pkg::PDIC_RUN;

	// =============================================================
	// Mode sequencing
	always_comb begin
		state_nxt   = state_r;
		pend_nxt    = pend_r;
		kbd_cnt_nxt = kbd_cnt_r;
		case (state_r)
			pdic_pkg::PDIC_RUN: begin
				if (power_down_request_bit) begin
					state_nxt = pdic_pkg::PDIC_PDOWN;
				end else if (cpu_halt_bit) begin
					state_nxt = pdic_pkg::PDIC_IDLE;
				end
			end
			pdic_pkg::PDIC_IDLE: begin
				if (idle_irq_in) begin
					state_nxt = pdic_pkg::PDIC_RUN;
				end
			end
			pdic_pkg::PDIC_PDOWN: begin
				if (ext_low != 2'b00) begin
					pend_nxt  = {2'b00, ext_low};
					state_nxt = pdic_pkg::PDIC_OSC_ON;
				end else if (kbd_wake) begin
					pend_nxt    = 4'h4;
					kbd_cnt_nxt = 16'h0000;
					state_nxt   = pdic_pkg::PDIC_KBD_WAIT;
				end else if (usb_wake) begin
					pend_nxt  = 4'h8;
					state_nxt = pdic_pkg::PDIC_WAKE;
				end
			end
			pdic_pkg::PDIC_OSC_ON: begin
				pend_nxt = pend_r | {2'b00, ext_low};
				if (ext_rise != 2'b00) begin
					state_nxt = pdic_pkg::PDIC_WAKE;
				end
			end
			pdic_pkg::PDIC_KBD_WAIT: begin
				kbd_cnt_nxt = kbd_cnt_r + 16'h0001;
				if (kbd_done) begin
					state_nxt = pdic_pkg::PDIC_WAKE;
				end
			end
			pdic_pkg::PDIC_WAKE: begin
				pend_nxt  = 4'h0;
				state_nxt = pdic_pkg::PDIC_RUN;
			end
			default: begin
				state_nxt = pdic_pkg::PDIC_RUN;
			end
		endcase
	end

	// =============================================================
	// Power control register
	always_comb begin
		power_control_nxt = power_control_r;
		if (sw_write) begin
			power_control_nxt = sfr_req_in.wdata & `PDIC_POWER_CONTROL_WMSK;
		end
		if (state_r == pdic_pkg::PDIC_IDLE && idle_irq_in) begin
			power_control_nxt[`PDIC_BIT_CPU_HALT] = 1'b0;
		end
		if (state_r == pdic_pkg::PDIC_WAKE) begin
			power_control_nxt[`PDIC_BIT_POWER_DOWN] = 1'b0;
			power_control_nxt[`PDIC_BIT_CPU_HALT]   = 1'b0;
		end
		if (cold_power_up_in) begin
			power_control_nxt[`PDIC_BIT_COLD_START] = 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			power_control_r <= `PDIC_POWER_CONTROL_RST;
		end else if (clk_en_in) begin
			if (rst_hit) begin
				power_control_r <= `PDIC_POWER_CONTROL_RST;
			end else begin
				power_control_r <= power_control_nxt;
			end
		end
	end

	// =============================================================
	// State, counters and pin history
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_r    <= pdic_pkg::PDIC_RUN;
			pend_r     <= 4'h0;
			kbd_cnt_r  <= 16'h0000;
			ext_prev_r <= 2'b11;
		end else if (clk_en_in) begin
			ext_prev_r <= ext_s;
			kbd_cnt_r  <= kbd_cnt_nxt;
			if (rst_hit) begin
				state_r <= pdic_pkg::PDIC_RUN;
				pend_r  <= 4'h0;
			end else begin
				state_r <= state_nxt;
				pend_r  <= pend_nxt;
			end
		end
	end

	// Reset pin qualification: the pin must stay high for the hold count.
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_cnt_r <= 8'h00;
		end else if (clk_en_in) begin
			if (!rst_pin_s) begin
				rst_cnt_r <= 8'h00;
			end else if (!rst_held) begin
				rst_cnt_r <= rst_cnt_r + 8'h01;
			end
		end
	end

	// =============================================================
	// Register read and wake vector
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sfr_rdata_out  <= 8'h00;
			wake_valid_out <= 1'b0;
			wake_src_out   <= pdic_pkg::PDIC_SRC_EXT0;
		end else if (clk_en_in) begin
			sfr_rdata_out  <= sfr_rd ? (power_control_r & `PDIC_POWER_CONTROL_WMSK) : 8'h00;
			wake_valid_out <= state_r == pdic_pkg::PDIC_WAKE && !rst_hit;
			if (state_r == pdic_pkg::PDIC_WAKE) begin
				wake_src_out <= pick_src(pend_r, wake_high_prio_in);
			end
		end
	end

	// =============================================================
	// Clock gating, retention and strobes
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			osc_run_out                <= 1'b1;
			cpu_clk_en_out             <= 1'b1;
			periph_clk_en_out          <= 1'b1;
			sfr_hold_out               <= 1'b0;
			ram_hold_out               <= 1'b0;
			core_reset_out             <= 1'b0;
			ale_out                    <= 1'b0;
			program_fetch_strobe_out   <= 1'b0;
			baud_doubler_out           <= 1'b0;
			serial_bit_view_select_out <= 1'b0;
		end else if (clk_en_in) begin
			osc_run_out       <= state_nxt != pdic_pkg::PDIC_PDOWN || rst_pin_s;
			cpu_clk_en_out    <= state_nxt == pdic_pkg::PDIC_RUN
			                  || state_nxt == pdic_pkg::PDIC_WAKE;
			periph_clk_en_out <= state_nxt == pdic_pkg::PDIC_RUN
			                  || state_nxt == pdic_pkg::PDIC_IDLE
			                  || state_nxt == pdic_pkg::PDIC_WAKE;
			sfr_hold_out      <= in_pdown;
			ram_hold_out      <= in_pdown;
			core_reset_out    <= rst_hit || rst_held;
			if (in_idle) begin
				ale_out                  <= 1'b1;
				program_fetch_strobe_out <= 1'b1;
			end else if (in_pdown) begin
				ale_out                  <= 1'b0;
				program_fetch_strobe_out <= 1'b0;
			end else begin
				ale_out                  <= core_ale_in;
				program_fetch_strobe_out <= core_prog_fetch_strobe_in;
			end
			baud_doubler_out           <= power_control_r[`PDIC_BIT_BAUD_DOUBLER];
			serial_bit_view_select_out <= power_control_r[`PDIC_BIT_VIEW_SELECT];
		end
	end

	// =============================================================
	// Port pins
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pins_out    <= '0;
			addr_hold_r <= 8'h00;
		end else if (clk_en_in) begin
			if (state_r == pdic_pkg::PDIC_RUN) begin
				addr_hold_r <= core_addr_hi_in;
			end
			if (in_idle || in_pdown) begin
				pins_out.p0_do <= core_pins_in.p0_do;
				pins_out.p0_oe <= ext_prog_mem_in ? 8'h00 : ~core_pins_in.p0_do;
				pins_out.p2_do <= (in_idle && ext_prog_mem_in) ? addr_hold_r
				                                               : core_pins_in.p2_do;
				pins_out.p2_oe <= (in_idle && ext_prog_mem_in) ? 8'hFF
				                                               : core_pins_in.p2_oe;
			end else begin
				pins_out <= core_pins_in;
			end
		end
	end

endmodule

`default_nettype wire

// >>> tb/pdic_props.sv
// Concurrent checks on the power controller's top-level ports.
// Assumes one clock domain and binding to every instance of the top module.
`default_nettype none

module pdic_props #(
	parameter int KBD_WAKE_CLKS = 1024,
	parameter int RST_HOLD_CLKS = 24
) (
	input wire logic                    clk_in,
	input wire logic                    rst_b_in,
	input wire pdic_pkg::pdic_sfr_req_t sfr_req_in,
	input wire logic [7:0]              sfr_rdata_out,
	input wire logic                    reset_pin_in,
	input wire logic [1:0]              ext_int_b_in,
	input wire logic [1:0]              ext_int_edge_in,
	input wire logic [3:0]              wake_enable_in,
	input wire logic                    ale_out,
	input wire logic                    program_fetch_strobe_out,
	input wire logic                    osc_run_out,
	input wire logic                    cpu_clk_en_out,
	input wire logic                    periph_clk_en_out,
	input wire logic                    sfr_hold_out,
	input wire logic                    ram_hold_out,
	input wire logic                    core_reset_out,
	input wire logic                    wake_valid_out,
	input wire pdic_pkg::pdic_src_t     wake_src_out,
	input wire logic                    baud_doubler_out,
	input wire logic                    serial_bit_view_select_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);

	// =============================================================
	// Counts raw cycles that the reset pin has been high.
	int hi_cnt_r;
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			hi_cnt_r <= 0;
		else if (!reset_pin_in)
			hi_cnt_r <= 0;
		else if (hi_cnt_r < 255)
			hi_cnt_r <= hi_cnt_r + 1;
	end

	// =============================================================
	// Checks
	sequence s_reg_read;
		sfr_req_in.rd && sfr_req_in.addr == 8'h87;
	endsequence
	sequence s_ext0_wake;
		!osc_run_out && wake_enable_in[0] && !ext_int_edge_in[0] && !ext_int_b_in[0];
	endsequence

	a_rsvd_reads_zero: assert property (s_reg_read |=> sfr_rdata_out[5] == 1'b0)
		else $error("reserved bit read as one");
	a_serial_bits_match: assert property (s_reg_read |=>
		sfr_rdata_out[7:6] == {baud_doubler_out, serial_bit_view_select_out})
		else $error("serial outputs differ from register");
	a_off_strobes_low: assert property (!osc_run_out |=> !ale_out && !program_fetch_strobe_out)
		else $error("strobes not low in power-down");
	a_off_state_held: assert property (!osc_run_out |=> sfr_hold_out && ram_hold_out)
		else $error("state not held in power-down");
	a_cpu_clk_periph: assert property (cpu_clk_en_out |-> periph_clk_en_out)
		else $error("peripheral clock off while cpu runs");
	a_wake_src_enabled: assert property (wake_valid_out |-> wake_enable_in[wake_src_out])
		else $error("wake from a disabled source");
	a_wake_one_pulse: assert property (wake_valid_out |=> !wake_valid_out)
		else $error("wake pulse longer than one cycle");
	a_ext_osc_restart: assert property (s_ext0_wake |-> ##[1:4] osc_run_out)
		else $error("oscillator not restarted by pin");
	a_reset_hold_time: assert property ($rose(core_reset_out) |-> hi_cnt_r >= RST_HOLD_CLKS)
		else $error("reset taken before hold time");
endmodule

bind pdic_top pdic_props #(.KBD_WAKE_CLKS(KBD_WAKE_CLKS), .RST_HOLD_CLKS(RST_HOLD_CLKS))
	pdic_props_inst (.clk_in(clk_in), .rst_b_in(rst_b_in), .sfr_req_in(sfr_req_in),
	.sfr_rdata_out(sfr_rdata_out), .reset_pin_in(reset_pin_in), .ext_int_b_in(ext_int_b_in),
	.ext_int_edge_in(ext_int_edge_in), .wake_enable_in(wake_enable_in), .ale_out(ale_out),
	.program_fetch_strobe_out(program_fetch_strobe_out), .osc_run_out(osc_run_out),
	.cpu_clk_en_out(cpu_clk_en_out), .periph_clk_en_out(periph_clk_en_out),
	.sfr_hold_out(sfr_hold_out), .ram_hold_out(ram_hold_out), .core_reset_out(core_reset_out),
	.wake_valid_out(wake_valid_out), .wake_src_out(wake_src_out),
	.baud_doubler_out(baud_doubler_out),
	.serial_bit_view_select_out(serial_bit_view_select_out));

`default_nettype wire

// >>> tb/pdic_wake_model.sv
// Wake-source model: external interrupt pins, keyboard and USB requests.
// Assumes the bench calls hold to raise one source for a number of cycles.
`default_nettype none

module pdic_wake_model (
	input  wire logic       clk_in,
	output var  logic [1:0] ext_int_b_out,
	output var  logic       kbd_int_out,
	output var  logic       usb_int_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// =============================================================
	// Sources idle; released pins are driven back high by the model.
	initial begin
		ext_int_b_out = 2'h3;
		kbd_int_out = 1'b0;
		usb_int_out = 1'b0;
	end

	function automatic void set_src(input int src, input logic on);
		case (src)
			0, 1: ext_int_b_out[src] = ~on;
			2: kbd_int_out = on;
			default: usb_int_out = on;
		endcase
	endfunction

	// Holds a source active for n clock cycles after the next edge, then releases it.
	task automatic hold(input int src, input int n);
		@(posedge clk_in);
		#1;
		set_src(src, 1'b1);
		repeat (n) @(posedge clk_in);
		#1;
		set_src(src, 1'b0);
	endtask
endmodule

`default_nettype wire

// >>> tb/pdic_top_tb_top.sv
// Self-checking bench for the power controller with a register model.
// Assumes the wake-source model and the bound checker are compiled first.
`default_nettype none

`define CHK(g, e) begin \
	tests_run++; \
	if ((g) !== (e)) begin \
		error_cnt++; \
		$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
	end \
end

module pdic_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int KBD = 8;
	localparam int RHOLD = 4;
	logic clk_in = 1'b0, rst_b_in = 1'b0, clk_en_in = 1'b1, cold_in = 1'b0, rst_pin = 1'b0;
	logic idle_irq = 1'b0, ext_mem = 1'b0, core_ale = 1'b1, core_strb = 1'b1;
	logic [1:0] ext_b, edge_cfg = 2'h0;
	logic kbd, usb, ale, strb, osc, cpu_en, per_en, sfr_hold, ram_hold, core_rst, wake, baud, view;
	logic [3:0] wake_en = 4'h0, prio = 4'h0;
	logic [7:0] addr_hi = 8'h00, rdata;
	pdic_pkg::pdic_sfr_req_t req = '0;
	pdic_pkg::pdic_pins_t core_pins = '0, pins;
	pdic_pkg::pdic_src_t src;
	int error_cnt = 0, tests_run = 0, seed = 94, cyc = 0, pc = 8'h10;

	pdic_wake_model pdic_wake_model_inst (.clk_in(clk_in), .ext_int_b_out(ext_b),
		.kbd_int_out(kbd), .usb_int_out(usb));

	pdic_top #(.KBD_WAKE_CLKS(KBD), .RST_HOLD_CLKS(RHOLD)) pdic_top_inst (.clk_in(clk_in),
		.rst_b_in(rst_b_in), .clk_en_in(clk_en_in), .sfr_req_in(req), .sfr_rdata_out(rdata),
		.cold_power_up_in(cold_in), .reset_pin_in(rst_pin), .ext_int_b_in(ext_b),
		.ext_int_edge_in(edge_cfg), .kbd_int_in(kbd), .usb_int_in(usb), .wake_enable_in(wake_en),
		.wake_high_prio_in(prio), .idle_irq_in(idle_irq), .ext_prog_mem_in(ext_mem),
		.core_ale_in(core_ale), .core_prog_fetch_strobe_in(core_strb), .core_pins_in(core_pins),
		.core_addr_hi_in(addr_hi), .pins_out(pins), .ale_out(ale), .program_fetch_strobe_out(strb),
		.osc_run_out(osc), .cpu_clk_en_out(cpu_en), .periph_clk_en_out(per_en),
		.sfr_hold_out(sfr_hold), .ram_hold_out(ram_hold), .core_reset_out(core_rst),
		.wake_valid_out(wake), .wake_src_out(src), .baud_doubler_out(baud),
		.serial_bit_view_select_out(view));

	// =============================================================
	// Clock, timeout and bus tasks
	initial begin
		forever #10 clk_in = ~clk_in;
	end

	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			results();
		end
	end

	task automatic tick(input int n = 1);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	task automatic wr(input logic [7:0] v);
		req = '{8'h87, 1'b1, 1'b0, v};
		tick();
		req.wr = 1'b0;
		pc = v & 8'hDF;
		tick();
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		req.addr = a;
		req.rd = 1'b1;
		tick();
		req.rd = 1'b0;
		d = rdata;
		tick();
	endtask

	task automatic results();
		$display("counts: tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// =============================================================
	// Scenarios
	initial begin
		logic [7:0] d, v;
		int n;
		pdic_pkg::pdic_src_t s;
		tick(4);
		rst_b_in = 1'b1;
		tick();
		rd(8'h87, d);
		`CHK(d, 8'h10)
		for (int i = 0; i < 8; i++) begin
			v = 8'($random(seed));
			wr(v & 8'hFC);
			rd(8'h87, d);
			`CHK(d, pc[7:0])
			`CHK({baud, view}, pc[7:6])
			rd({1'b0, v[6:0]}, d);
			`CHK(d, 8'h00)
		end
		wr(8'h00);
		cold_in = 1'b1;
		tick();
		cold_in = 1'b0;
		rd(8'h87, d);
		`CHK(d, 8'h10)
		$display("test register done");
		core_ale = 1'b0;
		core_strb = 1'b0;
		ext_mem = 1'b1;
		addr_hi = 8'($random(seed));
		wr(8'h0D);
		tick(3);
		`CHK({ale, strb, cpu_en, per_en}, 4'hD)
		`CHK(pins.p2_do, addr_hi)
		`CHK({pins.p0_oe, pins.p2_oe}, 16'h00FF)
		idle_irq = 1'b1;
		n = 0;
		while (cpu_en !== 1'b1 && n < 50) begin
			tick();
			n++;
		end
		idle_irq = 1'b0;
		`CHK(cpu_en, 1'b1)
		rd(8'h87, d);
		`CHK(d, 8'h0C)
		$display("test idle done");
		for (int k = 0; k < 4; k++) begin
			core_pins = pdic_pkg::pdic_pins_t'($random(seed));
			ext_mem = k[0];
			wake_en = 4'h1 << k;
			wr(k == 3 ? 8'h0F : 8'h0E);
			tick(2);
			`CHK({osc, ale, strb, sfr_hold, ram_hold}, 5'h03)
			`CHK(pins.p0_oe, k[0] ? 8'h00 : ~core_pins.p0_do)
			`CHK(pins.p2_do, core_pins.p2_do)
			`CHK(pins.p0_do, core_pins.p0_do)
			`CHK(pins.p2_oe, core_pins.p2_oe)
			pdic_wake_model_inst.hold((k + 1) % 4, 12);
			`CHK(osc, 1'b0)
			n = 0;
			fork
				pdic_wake_model_inst.hold(k, 20);
				begin
					while (wake !== 1'b1 && n < 2000) begin
						tick();
						n++;
					end
					s = src;
					`CHK(wake, 1'b1)
				end
			join
			`CHK(s, pdic_pkg::pdic_src_t'(k))
			if (k == 2) `CHK(n >= KBD, 1'b1)
			rd(8'h87, d);
			pc = pc & 8'hFC;
			`CHK(d, pc[7:0])
		end
		$display("test power-down done");
		wake_en = 4'h3;
		edge_cfg = 2'h3;
		prio = 4'h2;
		wr(8'h02);
		tick(2);
		n = 0;
		fork
			pdic_wake_model_inst.hold(0, 10);
			pdic_wake_model_inst.hold(1, 30);
			begin
				while (wake !== 1'b1 && n < 2000) begin
					tick();
					n++;
				end
				s = src;
				`CHK(wake, 1'b1)
			end
		join
		pc = pc & 8'hFC;
		`CHK(s, pdic_pkg::PDIC_SRC_EXT1)
		`CHK(n < 30, 1'b1)
		$display("test priority done");
		rst_pin = 1'b1;
		tick(RHOLD - 1);
		rst_pin = 1'b0;
		tick(4);
		rd(8'h87, d);
		`CHK(d, pc[7:0])
		wr(8'h0E);
		tick(3);
		rst_pin = 1'b1;
		tick(RHOLD + 6);
		`CHK({core_rst, osc}, 2'h3)
		rst_pin = 1'b0;
		tick(4);
		rd(8'h87, d);
		`CHK(d, 8'h10)
		$display("test reset pin done");
		results();
	end
endmodule

`default_nettype wire
